// ---- hw/ctps_top.sv ----
// Purpose: Five-input contact trigger preset sequencer, APB slave
// Assumes: frame_tick pulses once per video frame, inputs synchronous
// Notes:   Level triggers, delays counted in frame ticks
// Notes on behaviour
// RULE1: Exactly five independent trigger inputs.
// RULE2: Each input loads its list in order.
// RULE3: Output waits programmed frames, max 120.
// RULE4: Per-input load delay, up to 120 frames.
// RULE5: Level triggers, per-input polarity select.
// RULE6: Disabled input never advances nor loads; a manual step still advances and loads it.
// RULE7: List reset points first entry, no load.
// RULE8: Manual step advances and loads immediately.
// RULE9: Add, remove, remove-all, insert list edits.
// RULE10: Output fires manually or on flagged load.
// RULE11: Output save puts instruction into working settings.
// RULE12: Toggle flips output resting level.
// RULE13: Pulse level and width from polarity, delay.
// RULE14: Tally monitored, enabled by setting.
// RULE15: On-air lock rejects all control changes.
// RULE16: One advance per assertion, re-arm when inactive.
// RULE17: Partner holds level at least one frame.
`timescale 1ns/1ps
module ctps_top
  import ctps_pkg::*;
(
  // APB
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Timing base and pins
  input  wire logic                   frame_tick,
  input  wire logic [CTPS_NUM_IN-1:0] trig_in,
  input  wire logic                   tally_in,
  // Results
  output logic                        trig_out,
  output logic                        on_air,
  output logic                        load_strobe,
  output logic      [CTPS_FILE_W-1:0] load_file
);

  // Registers
  logic [31:0]            ctrl_q;
  logic [CTPS_DLY_W-1:0]  out_dly_q;
  logic [CTPS_DLY_W-1:0]  in_dly_q [CTPS_NUM_IN];
  logic [CTPS_FILE_W-1:0] list_q   [CTPS_NUM_IN][CTPS_LIST_DEPTH];
  logic [CTPS_CNT_W-1:0]  cnt_q    [CTPS_NUM_IN];
  logic [CTPS_PTR_W-1:0]  ptr_q    [CTPS_NUM_IN];
  logic [CTPS_NUM_IN-1:0] armed_q;
  logic [CTPS_NUM_IN-1:0] pend_q;
  logic [CTPS_DLY_W-1:0]  wait_q   [CTPS_NUM_IN];
  logic [CTPS_FILE_W-1:0] work_q;
  logic                   work_out_q;
  logic                   rest_hi_q;
  ctps_out_e              ost_q;
  logic [CTPS_DLY_W-1:0]  ocnt_q;
  logic [31:0]            prdata_q;
  logic                   pready_q;
  logic                   pslverr_q;
  logic                   trig_out_q;
  logic                   on_air_q;
  logic                   load_q;

  function automatic logic [CTPS_DLY_W-1:0] clamp_dly(input logic [CTPS_DLY_W-1:0] v);
    clamp_dly = (v > CTPS_MAX_DELAY) ? CTPS_MAX_DELAY : v; // see RULE3
  endfunction

  // Bus decode
  wire        acc      = psel && !penable;
  wire        wr       = acc && pwrite;
  ctps_cmd_s  cmd;
  assign cmd = ctps_cmd_s'({pwdata[3:0], pwdata[10:8], pwdata[15:12], pwdata[23:16]});
  wire        locked   = ctrl_q[CTPS_LOCK_EN] && on_air_q; // see RULE15
  wire        wr_ok    = wr && !locked;
  wire        wr_ctrl  = wr_ok && (paddr == CTPS_CTRL_OFF);
  wire        wr_cmd   = wr_ok && (paddr == CTPS_CMD_OFF) && (cmd.sel < 3'(CTPS_NUM_IN));
  wire        wr_odly  = wr_ok && (paddr == CTPS_OUTDLY_OFF);
  wire        in_rng   = (paddr >= CTPS_INDLY_OFF) && (paddr < CTPS_WORK_OFF);
  wire [2:0]  dly_sel  = 3'((paddr - CTPS_INDLY_OFF) >> 2);
  wire        wr_idly  = wr_ok && in_rng && (paddr[1:0] == 2'b00);
  wire        mapped   = (paddr == CTPS_CTRL_OFF) || (paddr == CTPS_CMD_OFF)
                      || (paddr == CTPS_STAT_OFF) || (paddr == CTPS_OUTDLY_OFF)
                      || in_rng || (paddr == CTPS_WORK_OFF) || (paddr == CTPS_LIST_OFF);
  wire        step_cmd = wr_cmd && (cmd.op == CTPS_OP_STEP);
  wire        fire_cmd = wr_cmd && (cmd.op == CTPS_OP_FIRE);

  // Trigger detection per input
  logic [CTPS_NUM_IN-1:0] active;
  logic [CTPS_NUM_IN-1:0] due;
  genvar g;
  generate
    for (g = 0; g < CTPS_NUM_IN; g++) // see RULE1
    begin : g_in
      // Level, not edge; polarity per input
      assign active[g] = ctrl_q[CTPS_EN_LSB+g]
                         && (trig_in[g] == ctrl_q[CTPS_HI_LSB+g]); // see RULE5; see RULE6
      assign due[g]    = pend_q[g] && (wait_q[g] == '0) && ctrl_q[CTPS_EN_LSB+g];
    end
  endgenerate

  // Lowest input wins when several come due together
  logic [2:0] due_idx;
  always_comb
  begin
    due_idx = 3'h7;
    for (int i = CTPS_NUM_IN - 1; i >= 0; i--)
      if (due[i])
        due_idx = 3'(i);
  end
  wire auto_load = (due_idx != 3'h7);
  wire [CTPS_FILE_W-1:0] auto_file = auto_load ? list_q[due_idx][ptr_q[due_idx]] : '0;
  wire [CTPS_FILE_W-1:0] step_file = list_q[cmd.sel][ptr_q[cmd.sel] + 4'h1];
  wire                   any_load  = step_cmd || auto_load;
  wire [CTPS_FILE_W-1:0] new_file  = step_cmd ? step_file : auto_file;
  // Only the loaded file's own flag counts, not the old working one
  wire out_start = fire_cmd
                || (any_load && new_file[CTPS_FILE_OUTBIT]); // see RULE10

  // Per-input sequencing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      armed_q <= '1;
      pend_q  <= '0;
      for (int i = 0; i < CTPS_NUM_IN; i++)
      begin
        ptr_q[i]    <= '0;
        wait_q[i]   <= '0;
        in_dly_q[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < CTPS_NUM_IN; i++)
      begin
        if (wr_idly && dly_sel == 3'(i))
          in_dly_q[i] <= clamp_dly(pwdata[CTPS_DLY_W-1:0]); // see RULE4
        // Re-arm only at the inactive level
        if (!active[i])
          armed_q[i] <= 1'b1; // see RULE16
        else if (armed_q[i] && !pend_q[i] && cnt_q[i] != '0)
        begin
          armed_q[i] <= 1'b0;
          pend_q[i]  <= 1'b1;
          wait_q[i]  <= in_dly_q[i]; // see RULE4
        end
        if (pend_q[i] && wait_q[i] != '0 && frame_tick)
          wait_q[i] <= wait_q[i] - 7'h1;
        if (!ctrl_q[CTPS_EN_LSB+i])
          pend_q[i] <= 1'b0; // see RULE6
        if (auto_load && due_idx == 3'(i))
        begin
          pend_q[i] <= 1'b0;
          // Wraps to the top after the last entry; compared at count width
          ptr_q[i]  <= (5'(ptr_q[i]) + 5'h1 >= cnt_q[i]) ? '0 : ptr_q[i] + 4'h1; // see RULE2
        end
        if (wr_cmd && cmd.sel == 3'(i))
          unique case (cmd.op)
            CTPS_OP_RESET, CTPS_OP_CLEAR: ptr_q[i] <= '0; // see RULE7
            CTPS_OP_STEP:  ptr_q[i] <= ptr_q[i] + 4'h1; // see RULE8
            default: ;
          endcase
      end
    end
  end

  // List storage and edits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int i = 0; i < CTPS_NUM_IN; i++)
      begin
        cnt_q[i] <= '0;
        for (int j = 0; j < CTPS_LIST_DEPTH; j++)
          list_q[i][j] <= '0;
      end
    else if (wr_cmd) // see RULE9
      unique case (cmd.op)
        CTPS_OP_ADD:
          if (cnt_q[cmd.sel] < 5'(CTPS_LIST_DEPTH))
          begin
            list_q[cmd.sel][cnt_q[cmd.sel][3:0]] <= cmd.file;
            cnt_q[cmd.sel] <= cnt_q[cmd.sel] + 5'h1;
          end
        CTPS_OP_INSERT:
          if (cnt_q[cmd.sel] < 5'(CTPS_LIST_DEPTH) && 5'(cmd.idx) <= cnt_q[cmd.sel])
          begin
            for (int j = 1; j < CTPS_LIST_DEPTH; j++)
              if (4'(j) > cmd.idx)
                list_q[cmd.sel][j] <= list_q[cmd.sel][j-1];
            list_q[cmd.sel][cmd.idx] <= cmd.file;
            cnt_q[cmd.sel] <= cnt_q[cmd.sel] + 5'h1;
          end
        CTPS_OP_REMOVE:
          if (5'(cmd.idx) < cnt_q[cmd.sel])
          begin
            for (int j = 0; j < CTPS_LIST_DEPTH - 1; j++)
              if (4'(j) >= cmd.idx)
                list_q[cmd.sel][j] <= list_q[cmd.sel][j+1];
            cnt_q[cmd.sel] <= cnt_q[cmd.sel] - 5'h1;
          end
        CTPS_OP_CLEAR: cnt_q[cmd.sel] <= '0;
        default: ;
      endcase
  end

  // Working settings, output sequencer, tally
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q     <= CTPS_CTRL_RST;
      out_dly_q  <= '0;
      work_q     <= '0;
      work_out_q <= 1'b0;
      rest_hi_q  <= 1'b0;
      ost_q      <= CTPS_OUT_IDLE;
      ocnt_q     <= '0;
      trig_out_q <= 1'b0;
      on_air_q   <= 1'b0;
      load_q     <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= pwdata;
      if (wr_odly)
        out_dly_q <= clamp_dly(pwdata[CTPS_DLY_W-1:0]); // see RULE3
      on_air_q <= ctrl_q[CTPS_TALLY_EN] && tally_in; // see RULE14
      load_q   <= any_load;
      if (any_load)
      begin
        work_q     <= new_file;
        work_out_q <= new_file[CTPS_FILE_OUTBIT];
      end
      else if (wr_ctrl && pwdata[CTPS_SAVE_OUT])
        work_out_q <= 1'b1; // see RULE11
      if (wr_cmd && cmd.op == CTPS_OP_TOGGLE)
        rest_hi_q <= !rest_hi_q; // see RULE12
      unique case (ost_q)
        CTPS_OUT_IDLE:
          if (out_start)
          begin
            ost_q  <= CTPS_OUT_WAIT;
            ocnt_q <= out_dly_q;
          end
        CTPS_OUT_WAIT:
          if (ocnt_q == '0)
          begin
            ost_q  <= CTPS_OUT_PULSE;
            ocnt_q <= (out_dly_q == '0) ? 7'h1 : out_dly_q; // see RULE13
          end
          else if (frame_tick)
            ocnt_q <= ocnt_q - 7'h1; // see RULE3
        CTPS_OUT_PULSE:
          if (ocnt_q == '0)
            ost_q <= CTPS_OUT_IDLE;
          else if (frame_tick)
            ocnt_q <= ocnt_q - 7'h1;
      endcase
      // Closure is the opposite of the resting level; see RULE13
      trig_out_q <= (ost_q == CTPS_OUT_PULSE) ? !rest_hi_q : rest_hi_q;
    end
  end

  // Read mux and APB answer
  wire [2:0] lsel = ctrl_q[26:24];
  logic [31:0] rd;
  always_comb
  begin
    rd = 32'h0;
    if (paddr == CTPS_CTRL_OFF)
      rd = ctrl_q;
    else if (paddr == CTPS_STAT_OFF)
      rd = {10'h0, ost_q, rest_hi_q, work_out_q, on_air_q, locked, 3'h0,
            pend_q, 3'h0, armed_q};
    else if (paddr == CTPS_OUTDLY_OFF)
      rd = {25'h0, out_dly_q};
    else if (in_rng && dly_sel < 3'(CTPS_NUM_IN))
      rd = {25'h0, in_dly_q[dly_sel]};
    else if (paddr == CTPS_WORK_OFF)
      rd = {24'h0, work_q};
    else if (paddr == CTPS_LIST_OFF && lsel < 3'(CTPS_NUM_IN))
      rd = {19'h0, cnt_q[lsel], 4'h0, ptr_q[lsel]};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= acc;
      // Locked writes are refused with an error
      pslverr_q <= acc && (!mapped || (pwrite && locked));
      if (acc)
        prdata_q <= rd;
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign trig_out    = trig_out_q;
  assign on_air      = on_air_q;
  assign load_strobe = load_q;
  assign load_file   = work_q;
endmodule

// ---- hw/ctps_pkg.sv ----
// Purpose: Shared constants and types for the contact trigger sequencer
// Assumes: 32-bit APB, 100 MHz pclk
// Notes:   Register offsets are byte addresses
package ctps_pkg;
  localparam int          CTPS_NUM_IN      = 5;
  localparam int          CTPS_LIST_DEPTH  = 16;
  localparam int          CTPS_PTR_W       = 4;
  localparam int          CTPS_CNT_W       = 5;
  localparam int          CTPS_FILE_W      = 8;
  localparam int          CTPS_DLY_W       = 7;
  localparam logic [6:0]  CTPS_MAX_DELAY   = 7'h78;
  // Register byte offsets
  localparam logic [7:0]  CTPS_CTRL_OFF    = 8'h00;
  localparam logic [7:0]  CTPS_CMD_OFF     = 8'h04;
  localparam logic [7:0]  CTPS_STAT_OFF    = 8'h08;
  localparam logic [7:0]  CTPS_OUTDLY_OFF  = 8'h0c;
  localparam logic [7:0]  CTPS_INDLY_OFF   = 8'h10;
  localparam logic [7:0]  CTPS_WORK_OFF    = 8'h24;
  localparam logic [7:0]  CTPS_LIST_OFF    = 8'h28;
  // CTRL fields
  localparam int          CTPS_EN_LSB      = 0;
  localparam int          CTPS_HI_LSB      = 8;
  localparam int          CTPS_TALLY_EN    = 16;
  localparam int          CTPS_LOCK_EN     = 17;
  localparam int          CTPS_SAVE_OUT    = 18;
  // CMD fields: [3:0] opcode, [10:8] input, [15:12] index, [23:16] file
  localparam logic [3:0]  CTPS_OP_ADD      = 4'h1;
  localparam logic [3:0]  CTPS_OP_REMOVE   = 4'h2;
  localparam logic [3:0]  CTPS_OP_CLEAR    = 4'h3;
  localparam logic [3:0]  CTPS_OP_INSERT   = 4'h4;
  localparam logic [3:0]  CTPS_OP_STEP     = 4'h5;
  localparam logic [3:0]  CTPS_OP_RESET    = 4'h6;
  localparam logic [3:0]  CTPS_OP_FIRE     = 4'h7;
  localparam logic [3:0]  CTPS_OP_TOGGLE   = 4'h8;
  localparam logic [31:0] CTPS_CTRL_RST    = 32'h0000_0000;
  // File entry bit 7 marks a stored output instruction
  localparam int          CTPS_FILE_OUTBIT = 7;

  typedef struct packed {
    logic [3:0]  op;
    logic [2:0]  sel;
    logic [3:0]  idx;
    logic [7:0]  file;
  } ctps_cmd_s;

  typedef enum logic [1:0] {
    CTPS_OUT_IDLE,
    CTPS_OUT_WAIT,
    CTPS_OUT_PULSE
  } ctps_out_e;
endpackage

// ---- test/ctps_props.sv ----
// Purpose: Port-level checks for the trigger sequencer
// Assumes: one clock domain, async active-low reset
// Notes:   Bound onto every ctps_top
`timescale 1ns/1ps
module ctps_props
  import ctps_pkg::*;
(
  // Bus side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins
  input wire logic        tally_in,
  input wire logic        on_air,
  input wire logic        load_strobe,
  input wire logic [7:0]  load_file
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_setup_gets_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_needs_setup: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_air_needs_tally: assert property (on_air |-> $past(tally_in))
    else $error("on air without tally");
  a_air_drops_late: assert property (!tally_in |=> !on_air)
    else $error("on air stuck");
  a_file_needs_load: assert property ($changed(load_file) |-> load_strobe)
    else $error("working file changed without a load");
endmodule

bind ctps_top ctps_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tally_in(tally_in), .on_air(on_air), .load_strobe(load_strobe),
  .load_file(load_file));

// ---- test/ctps_equip_model.sv ----
// Purpose: Switch-closure and tally equipment with frame cadence
// Assumes: bench sets wanted levels at any time
// Notes:   Levels move only on a frame tick
`timescale 1ns/1ps
module ctps_equip_model
  import ctps_pkg::*;
#(
  parameter int FRAME = 16
)
(
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Wanted levels
  input  wire logic [CTPS_NUM_IN-1:0] want_trig,
  input  wire logic                   want_tally,
  // Toward the device
  output logic                        frame_tick,
  output logic      [CTPS_NUM_IN-1:0] trig_in,
  output logic                        tally_in
);
  logic [7:0] cnt_q;
  // Latching on the tick holds every level a full frame
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt_q      <= 8'h00;
      frame_tick <= 1'b0;
      trig_in    <= '0;
      tally_in   <= 1'b0;
    end
    else
    begin
      cnt_q      <= (cnt_q == 8'(FRAME - 1)) ? 8'h00 : cnt_q + 8'h01;
      frame_tick <= (cnt_q == 8'(FRAME - 1));
      if (frame_tick)
      begin
        trig_in  <= want_trig;
        tally_in <= want_tally;
      end
    end
endmodule

// ---- test/contact_trigger_preset_sequencer_tb.sv ----
// Purpose: Self-checking bench for the trigger sequencer
// Assumes: 100 MHz pclk, equipment model makes frames
// Notes:   Each scenario judges its own results
`timescale 1ns/1ps
module contact_trigger_preset_sequencer_tb;
  import ctps_pkg::*;
  localparam int FR = 16;
  logic                   pclk = 0;
  logic                   presetn = 0;
  logic                   psel = 0;
  logic                   penable = 0;
  logic                   pwrite = 0;
  logic [7:0]             paddr = 0;
  logic [31:0]            pwdata = 0;
  logic [31:0]            prdata, rd;
  logic                   pready, pslverr, er;
  logic                   frame_tick, tally_in, trig_out, on_air, load_strobe;
  logic [CTPS_NUM_IN-1:0] trig_in;
  logic [CTPS_NUM_IN-1:0] want_trig = 0;
  logic                   want_tally = 0;
  logic [7:0]             load_file;
  int                     err_total = 0;
  int                     num_checks = 0;
  int                     n, s;

  always #5 pclk = ~pclk;

  ctps_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_tick(frame_tick), .trig_in(trig_in), .tally_in(tally_in),
    .trig_out(trig_out), .on_air(on_air), .load_strobe(load_strobe), .load_file(load_file));

  ctps_equip_model #(.FRAME(FR)) u_equip (.pclk(pclk), .presetn(presetn),
    .want_trig(want_trig), .want_tally(want_tally), .frame_tick(frame_tick),
    .trig_in(trig_in), .tally_in(tally_in));

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic cmd(input logic [3:0] op, input logic [2:0] i, input logic [3:0] x,
                     input logic [7:0] f);
    apb(1'b1, CTPS_CMD_OFF, {8'h00, f, x, 1'b0, i, 4'h0, op});
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits for trig_out (1) or load_strobe (0), bounded
  task automatic wt(input bit o, output int c);
    c = 0;
    while (((o ? trig_out : load_strobe) !== 1'b1) && c < 3000)
    begin
      @(posedge pclk);
      c++;
    end
  endtask

  task automatic cnt_ld(input int k, output int c);
    c = 0;
    repeat (k * FR)
    begin
      @(posedge pclk);
      c += (load_strobe === 1'b1);
    end
  endtask

  task automatic t_regs();
    apb(1'b0, CTPS_CTRL_OFF, 0);
    chk(rd, CTPS_CTRL_RST);
    apb(1'b1, CTPS_CTRL_OFF, 32'h40000);
    apb(1'b0, CTPS_STAT_OFF, 0);
    chk(rd & 32'h40000, 32'h40000);
    apb(1'b0, 8'h40, 0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, CTPS_OUTDLY_OFF, 32'hff);
    apb(1'b0, CTPS_OUTDLY_OFF, 0);
    chk(rd, 32'h78);
    apb(1'b1, CTPS_INDLY_OFF + 8'h10, 32'h79);
    apb(1'b0, CTPS_INDLY_OFF + 8'h10, 0);
    chk(rd, 32'h78);
    $display("t_regs done");
  endtask

  task automatic t_list();
    apb(1'b1, CTPS_INDLY_OFF, 32'h2);
    cmd(CTPS_OP_ADD, 0, 0, 8'h11);
    cmd(CTPS_OP_ADD, 0, 0, 8'h22);
    cmd(CTPS_OP_ADD, 0, 0, 8'h33);
    cmd(CTPS_OP_INSERT, 0, 1, 8'h44);
    cmd(CTPS_OP_REMOVE, 0, 0, 0);
    apb(1'b0, CTPS_LIST_OFF, 0);
    chk(rd, 32'h300);
    cmd(CTPS_OP_STEP, 0, 0, 0);
    chk({24'h0, load_file}, 32'h22);
    cmd(CTPS_OP_RESET, 0, 0, 0);
    apb(1'b0, CTPS_LIST_OFF, 0);
    chk(rd, 32'h300);
    chk({24'h0, load_file}, 32'h22);
    apb(1'b1, CTPS_CTRL_OFF, 32'h101);
    want_trig <= 5'h01;
    wt(1'b0, n);
    chk({24'h0, load_file}, 32'h44);
    chk({31'h0, n >= 2 * FR && n <= 5 * FR}, 32'h1);
    cnt_ld(6, s);
    chk(s, 0);
    want_trig <= 5'h00;
    cnt_ld(3, s);
    want_trig <= 5'h01;
    wt(1'b0, n);
    chk({24'h0, load_file}, 32'h22);
    cnt_ld(2, s);
    apb(1'b1, CTPS_CTRL_OFF, 32'h001);
    want_trig <= 5'h00;
    wt(1'b0, n);
    chk({24'h0, load_file}, 32'h33);
    apb(1'b1, CTPS_CTRL_OFF, 32'h000);
    want_trig <= 5'h01;
    cnt_ld(3, s);
    want_trig <= 5'h00;
    cnt_ld(6, n);
    chk(s + n, 0);
    cmd(CTPS_OP_CLEAR, 0, 0, 0);
    apb(1'b0, CTPS_LIST_OFF, 0);
    chk(rd, 32'h0);
    $display("t_list done");
  endtask

  task automatic t_out();
    apb(1'b1, CTPS_OUTDLY_OFF, 32'h2);
    cmd(CTPS_OP_FIRE, 0, 0, 0);
    wt(1'b1, n);
    // Fire lands anywhere inside a frame, so the first frame is partial
    chk({31'h0, n >= FR + 1 && n <= 2 * FR + 2}, 32'h1);
    n = 0;
    while (trig_out === 1'b1 && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, n >= 2 * FR - 1 && n <= 2 * FR + 1}, 32'h1);
    cmd(CTPS_OP_TOGGLE, 0, 0, 0);
    repeat (2) @(posedge pclk);
    chk({31'h0, trig_out}, 32'h1);
    cmd(CTPS_OP_TOGGLE, 0, 0, 0);
    repeat (2) @(posedge pclk);
    chk({31'h0, trig_out}, 32'h0);
    cmd(CTPS_OP_ADD, 1, 0, 8'h05);
    cmd(CTPS_OP_ADD, 1, 0, 8'h86);
    cmd(CTPS_OP_STEP, 1, 0, 0);
    wt(1'b1, n);
    chk({31'h0, n < 4 * FR}, 32'h1);
    cnt_ld(4, s);
    cmd(CTPS_OP_ADD, 1, 0, 8'h07);
    cmd(CTPS_OP_STEP, 1, 0, 0);
    chk({24'h0, load_file}, 32'h07);
    wt(1'b1, n);
    chk(n, 3000);
    $display("t_out done");
  endtask

  task automatic t_lock();
    apb(1'b1, CTPS_CTRL_OFF, 32'h30000);
    want_tally <= 1'b1;
    cnt_ld(2, s);
    chk({31'h0, on_air}, 32'h1);
    apb(1'b1, CTPS_CTRL_OFF, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, CTPS_CTRL_OFF, 0);
    chk(rd, 32'h30000);
    want_tally <= 1'b0;
    cnt_ld(2, s);
    chk({31'h0, on_air}, 32'h0);
    apb(1'b1, CTPS_CTRL_OFF, 32'h0);
    chk({31'h0, er}, 32'h0);
    $display("t_lock done");
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Whole run needs well under a third of this
  initial
  begin
    #500us;
    err_total++;
    end_of_test();
  end

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_list();
    t_out();
    t_lock();
    end_of_test();
  end
endmodule
